// File: logic/aca_pkg.sv
package aca_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ACA_CTRL_OFF = 8'h00;
    localparam logic [7:0] ACA_CONV_OFF = 8'h04;
    localparam logic [7:0] ACA_AVG_OFF = 8'h08;
    localparam logic [7:0] ACA_TRIG_OFF = 8'h0c;
    localparam logic [7:0] ACA_STAT_OFF = 8'h10;
    localparam logic [7:0] ACA_RESULT_OFF = 8'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ACA_CTRL_ENABLE_BIT = 0;
    localparam int ACA_CTRL_SWRST_BIT = 1;
    localparam int ACA_CONV_DIFF_BIT = 0;
    localparam int ACA_CONV_FREERUN_BIT = 1;
    localparam int ACA_CONV_STARTEV_BIT = 2;
    localparam int ACA_CONV_RESULT_RESOLUTION_SELECT_LSB = 4;
    localparam int ACA_CONV_SAMPLING_LENGTH_LSB = 8;
    localparam int ACA_AVG_COUNT_LSB = 0;
    localparam int ACA_AVG_ADJ_LSB = 4;
    localparam int ACA_TRIG_START_BIT = 1;
    localparam int ACA_STAT_READY_BIT = 0;
    localparam int ACA_STAT_OVERRUN_BIT = 1;
    localparam int ACA_STAT_BUSY_BIT = 2;
    // ------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------
    localparam logic [1:0] ACA_RESULT_RESOLUTION_SELECT_RESET = 2'h0;
    localparam logic [5:0] ACA_SAMPLING_LENGTH_RESET = 6'h00;
    localparam logic [3:0] ACA_COUNT_RESET = 4'h0;
    localparam logic [2:0] ACA_ADJ_RESET = 3'h0;
    localparam logic [3:0] ACA_COUNT_MAX_CODE = 4'ha;
    localparam logic [3:0] ACA_SHIFT_FREE_CODE = 4'h4;
    localparam int ACA_ACC_W = 22;
    localparam int ACA_RES_W = 16;
    localparam int ACA_SAMPLE_W = 12;
endpackage

// File: logic/aca_top.sv
// The implementer's own choices: the APB register port and the address map.
module aca_top #(
    parameter int CONV_CYCLES = 7
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // conversion clock enable and start event
    input wire logic conv_clk_en,
    input wire logic start_event,
    // analog core side
    input wire logic [11:0] sample_data,
    output logic sample_hold,
    output logic differential_select,
    output logic conv_active,
    output logic result_ready_flag
);
    import aca_pkg::*;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the phase counter is eight bits wide, so longer conversions cannot be timed
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_bad_conv_cycles
        $error("aca_top: CONV_CYCLES out of range");
    end

    typedef enum logic [1:0] {ACA_IDLE, ACA_SAMPLE, ACA_CONVERT} aca_state_e;

    typedef struct packed {
        // sequencer
        aca_state_e state;
        logic active;
        // configuration written by software
        logic enable;
        logic diff;
        logic freerun;
        logic start_ev_en;
        logic [1:0] result_resolution_select;
        logic [5:0] sampling_length;
        logic [3:0] count_code;
        logic [2:0] adj;
        // start and phase timing
        logic start_pend;
        logic [7:0] phase_cnt;
        // accumulation and result path
        logic [10:0] group_cnt;
        logic [ACA_ACC_W-1:0] acc;
        logic [ACA_RES_W-1:0] result;
        logic ready;
        logic overrun;
        logic hold;
        // bus answer, registered so every bus output leaves a flop
        logic [31:0] rdata;
        logic pready;
        logic pslverr;
    } aca_s;

    aca_s cur_reg, cur_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // reserved codes fall back to a single sample
    function automatic logic [3:0] aca_eff_code(input logic [3:0] code);
        return (code > ACA_COUNT_MAX_CODE) ? 4'h0 : code;
    endfunction

    function automatic logic [3:0] aca_auto_shift(input logic [3:0] code);
        logic [3:0] c;
        c = aca_eff_code(code);
        return (c > ACA_SHIFT_FREE_CODE) ? 4'(c - ACA_SHIFT_FREE_CODE) : 4'h0;
    endfunction

    function automatic logic [10:0] aca_group_len(input logic [3:0] code);
        return 11'(11'h001 << aca_eff_code(code));
    endfunction

    // total right shift of a finished group: automatic part plus the adjust field
    // reserved codes ignore the adjust field so they stay a plain single sample
    function automatic logic [4:0] aca_total_shift(input logic [3:0] code, input logic [2:0] adj);
        logic [4:0] adj_part;
        adj_part = (code > ACA_COUNT_MAX_CODE) ? 5'h00 : 5'(adj);
        return 5'(aca_auto_shift(code)) + adj_part;
    endfunction

    // ------------------------------------------------------------
    // timing overview
    // ------------------------------------------------------------
    // every conversion step happens on a cycle where conv_clk_en is high;
    // the bus side runs every cycle, so a start written by software or an
    // event is latched here first and only consumed on a later enable.
    // a conversion walks idle -> sample -> convert -> idle:
    //   idle    one enable to accept the start and open the sample switch
    //   sample  sampling length plus one enables with the hold output high
    //   convert CONV_CYCLES enables, the sample word is taken on the last
    // a group of several samples restarts by itself until the sample
    // counter wraps, so one trigger is enough for a whole average.
    // the accumulator is 22 bits, enough for 1024 full-scale samples, so
    // no saturation is needed before the final shift.
    // limitation: the sample word must be stable on the last convert
    // enable; the analog core is expected to hold it until then.

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic setup;
    logic start_req;
    logic last_in_group;
    logic [ACA_ACC_W-1:0] acc_sum;
    logic [ACA_ACC_W-1:0] shifted;
    logic [4:0] total_shift;

    always_comb begin
        cur_next = cur_reg;
        setup = psel && !penable;
        wr_acc = psel && penable && pwrite && cur_reg.pready;
        rd_acc = psel && penable && !pwrite && cur_reg.pready;
        start_req = 1'b0;
        last_in_group = 1'b0;
        acc_sum = '0;
        shifted = '0;
        total_shift = '0;

        // no wait state: answer in the cycle after setup
        cur_next.pready = setup;
        cur_next.pslverr = 1'b0;
        if (setup && !pwrite) begin
            unique case (paddr)
                ACA_CTRL_OFF: cur_next.rdata = {31'h0, cur_reg.enable};
                ACA_CONV_OFF: cur_next.rdata = {18'h0, cur_reg.sampling_length, 2'h0, cur_reg.result_resolution_select,
                                                1'b0, cur_reg.start_ev_en, cur_reg.freerun, cur_reg.diff};
                ACA_AVG_OFF: cur_next.rdata = {25'h0, cur_reg.adj, cur_reg.count_code};
                ACA_TRIG_OFF: cur_next.rdata = 32'h0;
                ACA_STAT_OFF: cur_next.rdata = {29'h0, (cur_reg.state != ACA_IDLE),
                                                cur_reg.overrun, cur_reg.ready};
                ACA_RESULT_OFF: cur_next.rdata = {16'h0, cur_reg.result};
                default: begin
                    cur_next.rdata = 32'h0;
                    cur_next.pslverr = 1'b1;
                end
            endcase
        end else if (setup) begin
            cur_next.rdata = 32'h0;
            unique case (paddr)
                ACA_CTRL_OFF, ACA_CONV_OFF, ACA_AVG_OFF, ACA_TRIG_OFF, ACA_STAT_OFF, ACA_RESULT_OFF: ;
                default: cur_next.pslverr = 1'b1;
            endcase
        end

        // reading the result acknowledges it
        if (rd_acc && paddr == ACA_RESULT_OFF) begin
            cur_next.ready = 1'b0;
        end

        // register writes
        if (wr_acc) begin
            unique case (paddr)
                ACA_CTRL_OFF: cur_next.enable = pwdata[ACA_CTRL_ENABLE_BIT];
                ACA_CONV_OFF: begin
                    cur_next.diff = pwdata[ACA_CONV_DIFF_BIT];
                    cur_next.freerun = pwdata[ACA_CONV_FREERUN_BIT];
                    cur_next.start_ev_en = pwdata[ACA_CONV_STARTEV_BIT];
                    cur_next.result_resolution_select = pwdata[ACA_CONV_RESULT_RESOLUTION_SELECT_LSB +: 2];
                    cur_next.sampling_length = pwdata[ACA_CONV_SAMPLING_LENGTH_LSB +: 6];
                end
                ACA_AVG_OFF: begin
                    cur_next.count_code = pwdata[ACA_AVG_COUNT_LSB +: 4];
                    cur_next.adj = pwdata[ACA_AVG_ADJ_LSB +: 3];
                end
                ACA_TRIG_OFF: begin
                    if (pwdata[ACA_TRIG_START_BIT] && cur_reg.enable) begin
                        cur_next.start_pend = 1'b1;
                    end
                end
                ACA_STAT_OFF: begin
                    // write one to clear
                    if (pwdata[ACA_STAT_READY_BIT]) begin
                        cur_next.ready = 1'b0;
                    end
                    if (pwdata[ACA_STAT_OVERRUN_BIT]) begin
                        cur_next.overrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // start event latched on the bus clock, used on a later conversion edge
        if (start_event && cur_reg.start_ev_en && cur_reg.enable) begin
            cur_next.start_pend = 1'b1;
        end
        // a group in progress keeps converting without a new trigger until complete
        start_req = cur_reg.start_pend || cur_reg.freerun || (cur_reg.group_cnt != 11'h000);

        // conversion sequencer on the conversion-clock enable
        if (conv_clk_en) begin
            unique case (cur_reg.state)
                ACA_IDLE: begin
                    if (cur_reg.enable && start_req) begin
                        cur_next.start_pend = 1'b0;
                        cur_next.state = ACA_SAMPLE;
                        cur_next.hold = 1'b1;
                        cur_next.phase_cnt = 8'(cur_reg.sampling_length);
                    end
                end
                ACA_SAMPLE: begin
                    if (cur_reg.phase_cnt == 8'h00) begin
                        cur_next.hold = 1'b0;
                        cur_next.state = ACA_CONVERT;
                        cur_next.phase_cnt = 8'(CONV_CYCLES - 1);
                    end else begin
                        cur_next.phase_cnt = 8'(cur_reg.phase_cnt - 8'h01);
                    end
                end
                ACA_CONVERT: begin
                    if (cur_reg.phase_cnt != 8'h00) begin
                        cur_next.phase_cnt = 8'(cur_reg.phase_cnt - 8'h01);
                    end else begin
                        acc_sum = cur_reg.acc + ACA_ACC_W'(sample_data);
                        last_in_group = (11'(cur_reg.group_cnt + 11'h001) == aca_group_len(cur_reg.count_code));
                        if (last_in_group) begin
                            // one shift of the full sum keeps the rounding of both parts alike
                            total_shift = aca_total_shift(cur_reg.count_code, cur_reg.adj);
                            shifted = acc_sum >> total_shift;
                            cur_next.result = shifted[ACA_RES_W-1:0];
                            if (cur_reg.ready) begin
                                cur_next.overrun = 1'b1;
                            end
                            cur_next.ready = 1'b1;
                            cur_next.acc = '0;
                            cur_next.group_cnt = '0;
                        end else begin
                            cur_next.acc = acc_sum;
                            cur_next.group_cnt = 11'(cur_reg.group_cnt + 11'h001);
                        end
                        cur_next.state = ACA_IDLE;
                    end
                end
                default: cur_next.state = ACA_IDLE;
            endcase
        end

        // disable aborts the sequence and empties the accumulator
        if (!cur_next.enable) begin
            cur_next.state = ACA_IDLE;
            cur_next.hold = 1'b0;
            cur_next.start_pend = 1'b0;
            cur_next.acc = '0;
            cur_next.group_cnt = '0;
        end

        // software reset returns every register to its reset value
        if (wr_acc && paddr == ACA_CTRL_OFF && pwdata[ACA_CTRL_SWRST_BIT]) begin
            cur_next = '0;
            cur_next.state = ACA_IDLE;
            cur_next.result_resolution_select = ACA_RESULT_RESOLUTION_SELECT_RESET;
            cur_next.sampling_length = ACA_SAMPLING_LENGTH_RESET;
            cur_next.count_code = ACA_COUNT_RESET;
            cur_next.adj = ACA_ADJ_RESET;
            cur_next.pready = 1'b0;
        end

        // busy flag is registered so conv_active comes straight from a flop
        cur_next.active = (cur_next.state != ACA_IDLE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // outputs straight from flops
    assign prdata = cur_reg.rdata;
    assign pready = cur_reg.pready;
    assign pslverr = cur_reg.pslverr;
    assign sample_hold = cur_reg.hold;
    assign differential_select = cur_reg.diff;
    assign conv_active = cur_reg.active;
    assign result_ready_flag = cur_reg.ready;
endmodule

// File: tb/aca_top_sva.sv
// --------------------
// bus and conversion checks
// --------------------
module aca_top_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    // conversion side
    input wire logic conv_clk_en,
    input wire logic sample_hold,
    input wire logic differential_select,
    input wire logic conv_active,
    input wire logic result_ready_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // the slave answers in the cycle right after setup, never longer
    property p_answer;
        psel && !penable |=> pready && penable;
    endproperty
    a_answer: assert property (p_answer) else $error("no pready after setup");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready held too long");
    // mode output only moves on a completed write
    property p_diff;
        $changed(differential_select) |-> $past(psel && penable && pwrite && pready);
    endproperty
    a_diff: assert property (p_diff) else $error("mode changed without write");
    // sampling opens only on a conversion clock edge
    property p_hold_rise;
        $rose(sample_hold) |-> $past(conv_clk_en) && conv_active;
    endproperty
    a_hold_rise: assert property (p_hold_rise) else $error("sampling off edge");
    // sampling closes on a conversion edge or an abort by write
    property p_hold_fall;
        $fell(sample_hold) |-> $past(conv_clk_en) || $past(psel && penable && pwrite);
    endproperty
    a_hold_fall: assert property (p_hold_fall) else $error("sampling cut short");
    property p_active;
        $rose(conv_active) |-> $past(conv_clk_en);
    endproperty
    a_active: assert property (p_active) else $error("conversion started off edge");
    // ready rises only as a conversion ends
    property p_ready;
        $rose(result_ready_flag) |-> $past(conv_active && conv_clk_en);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without conversion");
    property p_ready_fall;
        $fell(result_ready_flag) |-> $past(psel && penable && pready);
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready lost without access");
endmodule
bind aca_top aca_top_sva aca_top_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .conv_clk_en(conv_clk_en), .sample_hold(sample_hold),
    .differential_select(differential_select), .conv_active(conv_active),
    .result_ready_flag(result_ready_flag)
);

// File: tb/aca_tb_top.sv
module aca_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aca_pkg::*;
    // --------------------
    // signals, clock, design
    // --------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic conv_clk_en = 1'b0;
    logic start_event = 1'b0;
    logic [11:0] sample_data = 12'h000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sample_hold, differential_select, conv_active, result_ready_flag, err;
    int fail_count = 0;
    int n_compared = 0;
    // conversion clock edge every second bus cycle
    always #5 pclk = ~pclk;
    always @(posedge pclk) conv_clk_en <= ~conv_clk_en;
    aca_top #(.CONV_CYCLES(7)) aca_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_clk_en(conv_clk_en), .start_event(start_event),
        .sample_data(sample_data), .sample_hold(sample_hold), .differential_select(differential_select),
        .conv_active(conv_active), .result_ready_flag(result_ready_flag));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one transfer: request held until pready is seen high at a rising edge, data taken there
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look between edges: the value seen is the one the next rising edge samples
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("pready", {31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic wait_rdy(input int lim, output int w);
        w = 0;
        while (result_ready_flag !== 1'b1 && w < lim) begin
            @(negedge pclk);
            w++;
        end
        chk("ready", {31'h0, result_ready_flag}, 32'h1);
    endtask
    // n samples at sampling length sl; each sample needs sl+9 conversion edges
    task automatic conv(input logic [31:0] cfg, input logic [31:0] avg, input logic [11:0] s,
                        input int n, input int sl, input logic [15:0] exp);
        int w;
        sample_data <= s;
        apb(1'b1, ACA_CONV_OFF, cfg | (sl << ACA_CONV_SAMPLING_LENGTH_LSB));
        apb(1'b1, ACA_AVG_OFF, avg);
        apb(1'b1, ACA_TRIG_OFF, 32'h2);
        wait_rdy(n * (2 * sl + 20) + 8, w);
        chk("group length", {31'h0, w >= n * (2 * sl + 16) - 4}, 32'h1);
        apb(1'b0, ACA_RESULT_OFF, 32'h0);
        chk("result", rd, {16'h0, exp});
    endtask
    task automatic t_reset;
        chk("outs", {28'h0, sample_hold, differential_select, conv_active, result_ready_flag}, 32'h0);
        apb(1'b0, ACA_STAT_OFF, 32'h0);
        chk("stat", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", {31'h0, err}, 32'h1);
        apb(1'b1, ACA_CTRL_OFF, 32'h1);
        apb(1'b1, ACA_CONV_OFF, 32'h1);
        chk("diff", {31'h0, differential_select}, 32'h1);
        apb(1'b1, ACA_CONV_OFF, 32'h0);
        chk("diff", {31'h0, differential_select}, 32'h0);
        $display("test reset and mode done");
    endtask
    task automatic t_single;
        conv(32'h0, 32'h0, 12'habc, 1, 0, 16'h0abc);
        conv(32'h1, 32'h0, 12'h3c5, 1, 3, 16'h03c5);
        $display("test single done");
    endtask
    task automatic t_accum;
        conv(32'h10, 32'h2, 12'h123, 4, 0, 16'h048c);
        conv(32'h10, 32'h45, 12'hfff, 32, 0, 16'h0fff);
        conv(32'h10, 32'ha, 12'h801, 1024, 0, 16'h8010);
        conv(32'h10, 32'h4b, 12'h5a5, 1, 0, 16'h05a5);
        $display("test accumulate done");
    endtask
    // disable and reset in mid-group, then the next group must start clean
    task automatic t_abort;
        apb(1'b1, ACA_AVG_OFF, 32'h3);
        apb(1'b1, ACA_TRIG_OFF, 32'h2);
        repeat (40) @(posedge pclk);
        apb(1'b1, ACA_CTRL_OFF, 32'h0);
        apb(1'b1, ACA_CTRL_OFF, 32'h2);
        apb(1'b1, ACA_CTRL_OFF, 32'h1);
        apb(1'b0, ACA_STAT_OFF, 32'h0);
        chk("stat", rd, 32'h0);
        conv(32'h10, 32'h1, 12'h100, 2, 0, 16'h0200);
        $display("test abort done");
    endtask
    task automatic t_freerun;
        int w;
        conv(32'h2, 32'h0, 12'h0aa, 1, 0, 16'h00aa);
        wait_rdy(40, w);
        repeat (44) @(posedge pclk);
        apb(1'b0, ACA_STAT_OFF, 32'h0);
        chk("overrun", rd & 32'h3, 32'h3);
        apb(1'b1, ACA_CONV_OFF, 32'h0);
        repeat (44) @(posedge pclk);
        apb(1'b1, ACA_STAT_OFF, 32'h3);
        apb(1'b0, ACA_RESULT_OFF, 32'h0);
        chk("overwrite", rd, 32'h00aa);
        $display("test free-run done");
    endtask
    task automatic t_event;
        int w;
        apb(1'b1, ACA_CONV_OFF, 32'h4);
        sample_data <= 12'h0f0;
        @(posedge pclk);
        start_event <= 1'b1;
        @(posedge pclk);
        start_event <= 1'b0;
        wait_rdy(40, w);
        apb(1'b0, ACA_RESULT_OFF, 32'h0);
        chk("event result", rd, 32'h00f0);
        $display("test event done");
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_single();
        t_accum();
        t_abort();
        t_freerun();
        t_event();
        close_out();
    end
    // longest group is about 18k cycles
    initial begin
        #500000;
        fail_count++;
        close_out();
    end
endmodule
